/* design/qrsc_pkg.sv */
package qrsc_pkg;

	// Control clock
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned CLK_NS = 25;

	// Soft-start: total ramp and steps
	localparam int unsigned SS_TIME_MS = 12;
	localparam int unsigned SS_STEPS = 4;
	localparam int unsigned SS_STEP_CYC = (SS_TIME_MS * (CLK_HZ / 1000)) / SS_STEPS;
	// Peak ceiling codes in millivolts, start and end
	localparam logic [9:0] SS_START_MV = 10'h140;
	localparam logic [9:0] SS_END_MV = 10'h3E8;
	localparam logic [9:0] SS_INC_MV = 10'(({22'h0, SS_END_MV} - {22'h0, SS_START_MV}) / SS_STEPS);

	// Valley counter evaluation period
	localparam int unsigned EVAL_TIME_MS = 48;
	localparam int unsigned EVAL_CYC = EVAL_TIME_MS * (CLK_HZ / 1000);

	// Valley and crossing counter limits
	localparam logic [2:0] VALLEY_MIN = 3'h1;
	localparam logic [2:0] VALLEY_MAX = 3'h7;
	localparam logic [2:0] VALLEY_RST = 3'h1;
	localparam logic [2:0] ZC_MAX = 3'h7;

	// Overvoltage qualification time, rounded up
	localparam int unsigned OVP_TIME_US = 100;
	localparam int unsigned OVP_CYC = (OVP_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;

	// Unspecified intervals, plain defaults in cycles
	localparam int unsigned SHORT_SUPP_CYC = 40;
	localparam int unsigned LONG_SUPP_CYC = 120;
	localparam int unsigned MAX_OFF_CYC = 2000;
	localparam int unsigned LEB_CYC = 12;
	localparam int unsigned MAX_ON_CYC = 800;

	// Synchroniser depth
	localparam int unsigned SYNC_STAGES = 2;

	// Raw comparator results
	typedef struct packed {
		logic fb_above_up;      // feedback_level above count_up_threshold
		logic fb_above_down;    // feedback_level above count_down_threshold
		logic fb_above_reset;   // feedback_level above counter_reset_threshold
		logic cs_above_fb;      // scaled current sense above feedback_level
		logic ws_above_cross;   // winding sense above crossing_detect_threshold
		logic ws_above_ovp;     // winding sense above output_overvoltage_threshold
		logic ws_above_supp;    // winding sense above suppression_select_threshold
	} qrsc_cmp_s;

	localparam int unsigned CMP_W = $bits(qrsc_cmp_s);

	// Observed state
	typedef struct packed {
		logic [2:0] valley;
		logic [2:0] crossings;
		logic [9:0] ceiling_mv;
		logic soft_start;
		logic latched_off;
	} qrsc_stat_s;

endpackage : qrsc_pkg

/* design/qrsc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module qrsc_sync #(
	parameter int unsigned WIDTH = 1,
	parameter int unsigned STAGES = 2
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage_q [STAGES];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < int'(STAGES); i++) begin
				stage_q[i] <= '0;
			end
		end else begin
			stage_q[0] <= din;
			for (int i = 1; i < int'(STAGES); i++) begin
				stage_q[i] <= stage_q[i-1];
			end
		end
	end

	assign dout = stage_q[STAGES-1];
endmodule : qrsc_sync
`default_nettype wire

/* design/qrsc_top.sv */
// Summary of operation
// - At start, peak ceiling ramps digitally over 12 ms in four equal steps.
// - Ramp ceiling starts at 0.32 V and ends at 1 V.
// - Turn-on from crossings and valley count; turn-off from feedback versus current.
// - Feedback compared against three thresholds; valley counter updated every 48 ms.
// - Feedback always below low threshold: valley counter increments, saturating at 7.
// - Feedback crossed low but never high threshold: valley counter holds.
// - Feedback crossed high but not reset threshold: valley counter decrements to 1.
// - Feedback above reset threshold forces valley counter to 1 immediately.
// - Valley counter stays within 1 to 7; out-of-range steps are dropped.
// - Valley counter starts at 1 after reset.
// - Low and high thresholds chosen by line level, outside via comparator inputs.
// - After turn-off, each falling crossing of 100 mV adds one, up to 7.
// - Crossing counter clears whenever gate drive rises.
// - Winding sense above overvoltage threshold while off latches drive off.
// - Overvoltage must persist continuously 100 us before latch-off.
// - Suppression interval after turn-off: long if sense low, short otherwise.
// - Gate drive stays low throughout ringing suppression interval.
// - After suppression, turn on once crossings reach valley count.
// - Turn on after maximum off-time regardless of crossings, unless overvoltage latches drive off.
// - Turn off when scaled current sense exceeds feedback level.
// - Switch-off comparator ignored during leading-edge blanking, the minimum on-time.
// - Turn off when on longer than maximum on-time.
`timescale 1ns/1ps
`default_nettype none
module qrsc_top
	import qrsc_pkg::*;
#(
	parameter int unsigned SS_STEP_CYCLES = SS_STEP_CYC,
	parameter int unsigned EVAL_CYCLES = EVAL_CYC,
	parameter int unsigned OVP_CYCLES = OVP_CYC,
	parameter int unsigned SHORT_SUPP_CYCLES = SHORT_SUPP_CYC,
	parameter int unsigned LONG_SUPP_CYCLES = LONG_SUPP_CYC,
	parameter int unsigned MAX_OFF_CYCLES = MAX_OFF_CYC,
	parameter int unsigned LEB_CYCLES = LEB_CYC,
	parameter int unsigned MAX_ON_CYCLES = MAX_ON_CYC
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire qrsc_pkg::qrsc_cmp_s cmp_raw,
	output logic gate_drive_output,
	output logic [9:0] peak_ceiling_mv,
	output qrsc_pkg::qrsc_stat_s status
);
	import qrsc_pkg::*;

	localparam int CW = 32;

	typedef enum logic [1:0] {
		QRSC_OFF_SUPP = 2'b00,
		QRSC_OFF_WAIT = 2'b01,
		QRSC_ON = 2'b10,
		QRSC_LATCHED = 2'b11
	} qrsc_state_e;

	qrsc_cmp_s cmp;
	qrsc_state_e state_q;
	logic [CW-1:0] phase_cnt_q;
	logic [CW-1:0] ss_cnt_q;
	logic [2:0] ss_step_q;
	logic [9:0] ceiling_q;
	logic [CW-1:0] eval_cnt_q;
	logic seen_up_q;
	logic seen_down_q;
	logic [2:0] valley_q;
	logic [2:0] zc_q;
	logic ws_cross_prev_q;
	logic [CW-1:0] ovp_cnt_q;
	logic ovp_trip;
	logic [CW-1:0] supp_len_q;
	logic gate_q;
	logic period_end;
	logic turn_on;
	logic turn_off;
	logic cross_fall;

	qrsc_sync #(
		.WIDTH(CMP_W),
		.STAGES(SYNC_STAGES)
	) u_sync (
		.clk(clk),
		.arst_n(arst_n),
		.din(cmp_raw),
		.dout(cmp)
	);

	// Soft-start ramp of the peak ceiling
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ss_cnt_q <= '0;
			ss_step_q <= '0;
			ceiling_q <= SS_START_MV;
		end else if (ss_step_q < 3'(SS_STEPS)) begin
			if (ss_cnt_q >= CW'(SS_STEP_CYCLES - 1)) begin
				ss_cnt_q <= '0;
				ss_step_q <= ss_step_q + 3'h1;
				ceiling_q <= (ss_step_q == 3'(SS_STEPS - 1)) ? SS_END_MV : ceiling_q + SS_INC_MV;
			end else begin
				ss_cnt_q <= ss_cnt_q + CW'(1);
			end
		end
	end

	// Evaluation period timer
	assign period_end = (eval_cnt_q >= CW'(EVAL_CYCLES - 1));

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			eval_cnt_q <= '0;
		end else if (period_end) begin
			eval_cnt_q <= '0;
		end else begin
			eval_cnt_q <= eval_cnt_q + CW'(1);
		end
	end

	// Threshold crossings seen within the current period
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			seen_up_q <= 1'b0;
			seen_down_q <= 1'b0;
		end else if (period_end) begin
			seen_up_q <= 1'b0;
			seen_down_q <= 1'b0;
		end else begin
			seen_up_q <= seen_up_q | cmp.fb_above_up;
			seen_down_q <= seen_down_q | cmp.fb_above_down;
		end
	end

	// Valley counter
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			valley_q <= VALLEY_RST;
		end else if (cmp.fb_above_reset) begin
			valley_q <= VALLEY_RST;
		end else if (period_end) begin
			if (!(seen_up_q | cmp.fb_above_up)) begin
				if (valley_q < VALLEY_MAX) begin
					valley_q <= valley_q + 3'h1;
				end
			end else if (seen_down_q | cmp.fb_above_down) begin
				if (valley_q > VALLEY_MIN) begin
					valley_q <= valley_q - 3'h1;
				end
			end
			// Crossed only the low threshold: hold value
		end
	end

	// Falling crossings of the winding sense while off
	assign cross_fall = ws_cross_prev_q & ~cmp.ws_above_cross;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ws_cross_prev_q <= 1'b0;
		end else begin
			ws_cross_prev_q <= cmp.ws_above_cross;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			zc_q <= '0;
		end else if (turn_on) begin
			zc_q <= '0;
		end else if (!gate_q && cross_fall && zc_q < ZC_MAX) begin
			zc_q <= zc_q + 3'h1;
		end
	end

	// Output overvoltage qualification during off-time
	assign ovp_trip = (ovp_cnt_q >= CW'(OVP_CYCLES - 1)) && cmp.ws_above_ovp && !gate_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ovp_cnt_q <= '0;
		end else if (gate_q || !cmp.ws_above_ovp) begin
			ovp_cnt_q <= '0;
		end else if (!ovp_trip) begin
			ovp_cnt_q <= ovp_cnt_q + CW'(1);
		end
	end

	// Switch decisions
	always_comb begin
		turn_on = 1'b0;
		turn_off = 1'b0;
		unique case (state_q)
			QRSC_OFF_SUPP: turn_on = !ovp_trip && phase_cnt_q >= CW'(MAX_OFF_CYCLES - 1);
			QRSC_OFF_WAIT: turn_on = !ovp_trip && (zc_q >= valley_q
				|| phase_cnt_q >= CW'(MAX_OFF_CYCLES - 1));
			QRSC_ON: turn_off = ovp_trip || phase_cnt_q >= CW'(MAX_ON_CYCLES - 1)
				|| (cmp.cs_above_fb && phase_cnt_q >= CW'(LEB_CYCLES));
			QRSC_LATCHED: turn_on = 1'b0;
		endcase
	end

	// Gate state machine; phase counter times both on and off intervals
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= QRSC_OFF_SUPP;
			phase_cnt_q <= '0;
			supp_len_q <= CW'(LONG_SUPP_CYCLES);
			gate_q <= 1'b0;
		end else begin
			unique case (state_q)
				QRSC_OFF_SUPP: begin
					phase_cnt_q <= phase_cnt_q + CW'(1);
					if (ovp_trip) begin
						state_q <= QRSC_LATCHED;
					end else if (turn_on) begin
						state_q <= QRSC_ON;
						phase_cnt_q <= '0;
						gate_q <= 1'b1;
					end else if (phase_cnt_q >= supp_len_q - CW'(1)) begin
						state_q <= QRSC_OFF_WAIT;
					end
				end
				QRSC_OFF_WAIT: begin
					phase_cnt_q <= phase_cnt_q + CW'(1);
					if (ovp_trip) begin
						state_q <= QRSC_LATCHED;
					end else if (turn_on) begin
						state_q <= QRSC_ON;
						phase_cnt_q <= '0;
						gate_q <= 1'b1;
					end
				end
				QRSC_ON: begin
					phase_cnt_q <= phase_cnt_q + CW'(1);
					if (turn_off) begin
						state_q <= QRSC_OFF_SUPP;
						phase_cnt_q <= '0;
						gate_q <= 1'b0;
						// Interval chosen from winding level at turn-off
						supp_len_q <= cmp.ws_above_supp ? CW'(SHORT_SUPP_CYCLES)
							: CW'(LONG_SUPP_CYCLES);
					end
				end
				QRSC_LATCHED: begin
					gate_q <= 1'b0;
				end
			endcase
		end
	end

	assign gate_drive_output = gate_q;
	assign peak_ceiling_mv = ceiling_q;
	// Line-level threshold selection happens in the comparator bank
	assign status = '{valley: valley_q, crossings: zc_q, ceiling_mv: ceiling_q,
		soft_start: (ss_step_q < 3'(SS_STEPS)), latched_off: (state_q == QRSC_LATCHED)};
endmodule : qrsc_top
`default_nettype wire

/* verification/qrsc_cmp_model.sv */
`timescale 1ns/1ps
`default_nettype none
module qrsc_cmp_model (
	input wire logic clk,
	input wire logic gate,
	input wire logic [1:0] fb_lvl,
	input wire logic cs_en,
	input wire logic ring,
	input wire logic ovp,
	input wire logic supp,
	output qrsc_pkg::qrsc_cmp_s cmp
);
	import qrsc_pkg::*;
	logic [1:0] ph_q = 2'h0;
	always_ff @(posedge clk) begin
		ph_q <= ph_q + 2'h1;
	end
	// Winding crossing and overvoltage outputs are clamped low while the switch conducts
	always_comb begin
		cmp.fb_above_up = fb_lvl != 2'h0;
		cmp.fb_above_down = fb_lvl[1];
		cmp.fb_above_reset = fb_lvl == 2'h3;
		cmp.cs_above_fb = cs_en & gate;
		cmp.ws_above_cross = ring & ~gate & ph_q[1];
		cmp.ws_above_ovp = ovp & ~gate;
		cmp.ws_above_supp = supp;
	end
endmodule : qrsc_cmp_model
`default_nettype wire

/* verification/qrsc_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module qrsc_properties #(
	parameter int unsigned LEB_CYCLES = 12,
	parameter int unsigned MAX_ON_CYCLES = 800,
	parameter int unsigned MAX_OFF_CYCLES = 2000,
	parameter int unsigned SHORT_SUPP_CYCLES = 40
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire qrsc_pkg::qrsc_cmp_s cmp_raw,
	input wire logic gate_drive_output,
	input wire logic [9:0] peak_ceiling_mv,
	input wire qrsc_pkg::qrsc_stat_s status
);
	import qrsc_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic [15:0] on_q;
	logic [15:0] off_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			on_q <= 16'h0;
			off_q <= 16'h0;
		end else begin
			on_q <= gate_drive_output ? on_q + 16'h1 : 16'h0;
			off_q <= gate_drive_output ? 16'h0 : off_q + 16'h1;
		end
	end
	sequence s_turn_on;
		$rose(gate_drive_output);
	endsequence
	sequence s_turn_off;
		$fell(gate_drive_output);
	endsequence
	a_valley_range: assert property (status.valley != 3'h0) else $error("valley out of range");
	a_reset_force: assert property (cmp_raw.fb_above_reset [*4] |-> status.valley == 3'h1)
		else $error("valley not forced");
	a_cross_clear: assert property (s_turn_on |-> status.crossings == 3'h0) else $error("crossings kept");
	a_leb_min: assert property (s_turn_off |-> on_q >= LEB_CYCLES) else $error("on-time too short");
	a_max_on: assert property (gate_drive_output |-> on_q <= MAX_ON_CYCLES + 1) else $error("on too long");
	a_max_off: assert property (!gate_drive_output && !status.latched_off |-> off_q <= MAX_OFF_CYCLES + 2)
		else $error("off too long");
	a_supp_hold: assert property (s_turn_on |-> $past(off_q) >= SHORT_SUPP_CYCLES - 1)
		else $error("rise in suppression");
	a_latch_hold: assert property (status.latched_off |=> status.latched_off && !gate_drive_output)
		else $error("latch released");
	a_ceil_step: assert property ($changed(peak_ceiling_mv) |-> peak_ceiling_mv == $past(peak_ceiling_mv) + 10'h0AA)
		else $error("ceiling step wrong");
	a_ceil_end: assert property (!status.soft_start |-> peak_ceiling_mv == 10'h3E8) else $error("ceiling end");
endmodule : qrsc_properties
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import qrsc_pkg::*;
	localparam int EV = 100;
	localparam int LEB = 5;
	localparam int MXON = 60;
	localparam int MXOFF = 200;
	localparam int SHS = 10;
	localparam int LGS = 30;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [1:0] fb_lvl = 2'h0;
	logic cs_en = 1'b1;
	logic ring = 1'b1;
	logic ovp = 1'b0;
	logic supp = 1'b0;
	qrsc_cmp_s cmp;
	logic gate;
	logic [9:0] ceil_mv;
	qrsc_stat_s stat;
	int err_count = 0;
	int compares = 0;
	int n;
	always #12.5 clk = ~clk;
	qrsc_top #(.SS_STEP_CYCLES(50), .EVAL_CYCLES(EV), .OVP_CYCLES(20), .SHORT_SUPP_CYCLES(SHS),
		.LONG_SUPP_CYCLES(LGS), .MAX_OFF_CYCLES(MXOFF), .LEB_CYCLES(LEB), .MAX_ON_CYCLES(MXON)) qrsc_top_inst (
		.clk(clk), .arst_n(arst_n), .cmp_raw(cmp), .gate_drive_output(gate), .peak_ceiling_mv(ceil_mv), .status(stat));
	qrsc_cmp_model qrsc_cmp_model_inst (.clk(clk), .gate(gate), .fb_lvl(fb_lvl), .cs_en(cs_en), .ring(ring),
		.ovp(ovp), .supp(supp), .cmp(cmp));
	task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", w, exp, seen);
		end
	endtask : check
	task automatic rng(input string w, input int v, input int lo, input int hi);
		check(w, {31'h0, (v >= lo) && (v <= hi)}, 32'h1);
	endtask : rng
	task automatic test_done;
		if (err_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done
	// Length of the next fresh interval with gate at level lv
	task automatic span(input logic lv, output int len);
		len = 0;
		while (gate === lv) @(negedge clk);
		while (gate !== lv) @(negedge clk);
		while (gate === lv) begin
			len++;
			@(negedge clk);
		end
	endtask : span
	task automatic t_reset;
		@(negedge clk);
		check("reset", {gate, ceil_mv, stat}, {1'b0, 10'h140, 3'h1, 3'h0, 10'h140, 1'b1, 1'b0});
		@(posedge clk);
		arst_n <= 1'b1;
	endtask : t_reset
	// Level changes land mid-period so every period is classified cleanly
	task automatic t_valley;
		logic [1:0] lv [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
		logic [2:0] ex [4] = '{3'h7, 3'h7, 3'h6, 3'h5};
		repeat (50 + 6 * EV) @(negedge clk);
		check("valley up", stat.valley, 3'h7);
		check("ramp end", {ceil_mv, stat.soft_start}, {10'h3E8, 1'b0});
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			fb_lvl <= lv[i];
			repeat (EV) @(negedge clk);
			check("valley step", stat.valley, ex[i]);
		end
		@(posedge clk);
		fb_lvl <= 2'h3;
		repeat (6) @(negedge clk);
		check("valley reset", stat.valley, 3'h1);
		@(posedge clk);
		fb_lvl <= 2'h1;
	endtask : t_valley
	task automatic t_switch;
		span(1'b0, n);
		rng("long supp", n, LGS, LGS + 8);
		@(posedge clk);
		supp <= 1'b1;
		span(1'b0, n);
		rng("short supp", n, SHS, SHS + 8);
		span(1'b1, n);
		rng("blanked on", n, LEB + 1, LEB + 4);
		@(posedge clk);
		cs_en <= 1'b0;
		span(1'b1, n);
		rng("max on", n, MXON, MXON + 2);
		@(posedge clk);
		cs_en <= 1'b1;
		ring <= 1'b0;
		span(1'b0, n);
		rng("max off", n, MXOFF, MXOFF + 2);
	endtask : t_switch
	task automatic t_ovp(input int len, input logic exp);
		while (gate !== 1'b1) @(negedge clk);
		while (gate !== 1'b0) @(negedge clk);
		@(posedge clk);
		ovp <= 1'b1;
		repeat (len) @(posedge clk);
		ovp <= 1'b0;
		repeat (300) @(negedge clk);
		check("latched", {stat.latched_off, gate}, {exp, 1'b0});
	endtask : t_ovp
	initial begin
		repeat (4) @(posedge clk);
		t_reset();
		t_valley();
		t_switch();
		t_ovp(10, 1'b0);
		t_ovp(40, 1'b1);
		@(posedge clk);
		arst_n <= 1'b0;
		t_reset();
		test_done();
	end
	initial begin
		#(25 * 10000);
		err_count++;
		test_done();
	end
endmodule : testbench
bind qrsc_top qrsc_properties #(.LEB_CYCLES(LEB_CYCLES), .MAX_ON_CYCLES(MAX_ON_CYCLES),
	.MAX_OFF_CYCLES(MAX_OFF_CYCLES), .SHORT_SUPP_CYCLES(SHORT_SUPP_CYCLES)) qrsc_properties_inst (
	.clk, .arst_n, .cmp_raw, .gate_drive_output, .peak_ceiling_mv, .status);
`default_nettype wire
